/* hdl/pasc_core.sv */
// address mapping, table addressing and stack checking logic
`timescale 1ns/1ps
module pasc_core (
  // clock, reset, enable
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // register port
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  // core access request
  input wire pasc_pkg::pasc_req_t REQ_IN,
  // mapped access and trap pulses
  output pasc_pkg::pasc_rsp_t RSP_OUT
);
  // state copy and registered state
  pasc_pkg::pasc_state_t s_q;
  pasc_pkg::pasc_state_t s_d;
  // next state: registers, address forming, traps
  always_comb begin
    logic [15:0] ea;
    logic [15:0] sp_new;
    logic hi;
    s_d = s_q;
    ea = REQ_IN.ea;
    sp_new = s_q.stk_ptr;
    hi = REQ_IN.ea[pasc_pkg::PASC_EA_WINDOW_BIT];
    s_d.rsp = '0; // RULE23
    s_d.rdata = 16'h0000;
    // register writes; a trap in the same cycle still sets sticky bits
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        pasc_pkg::PASC_OFF_RD_PAGE: s_d.rd_page = REG_WDATA_IN[9:0]; // RULE16
        pasc_pkg::PASC_OFF_WR_PAGE: s_d.wr_page = REG_WDATA_IN[8:0];
        pasc_pkg::PASC_OFF_TBL_PAGE: s_d.tbl_page = REG_WDATA_IN[7:0];
        pasc_pkg::PASC_OFF_STK_LIMIT: s_d.stk_limit = {REG_WDATA_IN[15:1], 1'b0}; // RULE10
        pasc_pkg::PASC_OFF_STK_PTR: s_d.stk_ptr = {REG_WDATA_IN[15:1], 1'b0}; // RULE6
        pasc_pkg::PASC_OFF_STATUS: s_d.sticky = s_q.sticky & ~REG_WDATA_IN[2:0];
        default: s_d.sticky = s_q.sticky;
      endcase
    end
    // register reads answer one cycle later
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        pasc_pkg::PASC_OFF_RD_PAGE: s_d.rdata = {6'h00, s_q.rd_page};
        pasc_pkg::PASC_OFF_WR_PAGE: s_d.rdata = {7'h00, s_q.wr_page};
        pasc_pkg::PASC_OFF_TBL_PAGE: s_d.rdata = {8'h00, s_q.tbl_page};
        pasc_pkg::PASC_OFF_STK_LIMIT: s_d.rdata = {s_q.stk_limit[15:1], 1'b0}; // RULE10
        pasc_pkg::PASC_OFF_STK_PTR: s_d.rdata = s_q.stk_ptr;
        pasc_pkg::PASC_OFF_STATUS: s_d.rdata = {13'h0000, s_q.sticky};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    // access decode
    if (REQ_IN.valid) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.data = REQ_IN.data;
      case (REQ_IN.op)
        pasc_pkg::PASC_OP_RD: begin
          if (!REQ_IN.indirect || !hi) begin
            s_d.rsp.to_data = 1'b1; // RULE1
            s_d.rsp.addr = {8'h00, ea};
          end else if (s_q.rd_page == 10'h000) begin
            s_d.rsp.addr_err = 1'b1; // RULE2
          end else if (s_q.rd_page[pasc_pkg::PASC_RD_PSV_BIT]) begin
            // program view, user space only
            s_d.rsp.to_prog = 1'b1; // RULE17
            s_d.rsp.prog_upper = s_q.rd_page[pasc_pkg::PASC_RD_UPPER_BIT]; // RULE18
            s_d.rsp.prog_cfg = 1'b0; // RULE19
            s_d.rsp.addr = {1'b0, s_q.rd_page[7:0], ea[14:0]}; // RULE17
          end else begin
            s_d.rsp.to_data = 1'b1;
            s_d.rsp.addr = {s_q.rd_page[8:0], ea[14:0]}; // RULE5 RULE3
          end
        end
        pasc_pkg::PASC_OP_WR: begin
          s_d.rsp.is_write = 1'b1;
          if (!REQ_IN.indirect || !hi) begin
            s_d.rsp.to_data = 1'b1; // RULE1
            s_d.rsp.addr = {8'h00, ea};
          end else if (s_q.wr_page == 9'h000) begin
            s_d.rsp.addr_err = 1'b1; // RULE2
          end else begin
            s_d.rsp.to_data = 1'b1;
            s_d.rsp.addr = {s_q.wr_page, ea[14:0]}; // RULE4 RULE3
          end
        end
        pasc_pkg::PASC_OP_PUSH: begin
          s_d.rsp.is_write = 1'b1;
          s_d.rsp.addr = {8'h00, s_q.stk_ptr};
          // upper pc word carries zero or the flags byte
          if (REQ_IN.push_kind == pasc_pkg::PASC_PUSH_CALL) begin
            s_d.rsp.data = {8'h00, REQ_IN.data[7:0]}; // RULE8
          end else if (REQ_IN.push_kind == pasc_pkg::PASC_PUSH_EXC) begin
            s_d.rsp.data = {REQ_IN.flags, REQ_IN.data[7:0]}; // RULE9
          end
          if (s_q.stk_ptr > s_q.stk_limit || s_q.stk_ptr < pasc_pkg::PASC_STK_FLOOR) begin
            s_d.rsp.stk_err = 1'b1; // RULE11 RULE12
          end else begin
            s_d.rsp.to_data = 1'b1;
            sp_new = s_q.stk_ptr + pasc_pkg::PASC_WORD_STEP; // RULE7
          end
        end
        pasc_pkg::PASC_OP_POP: begin
          sp_new = s_q.stk_ptr - pasc_pkg::PASC_WORD_STEP; // RULE7
          s_d.rsp.addr = {8'h00, sp_new};
          // a pop under the floor is refused; pointer kept
          if (sp_new < pasc_pkg::PASC_STK_FLOOR || sp_new > s_q.stk_limit) begin
            s_d.rsp.stk_err = 1'b1; // RULE12 RULE11
            sp_new = s_q.stk_ptr;
          end else begin
            s_d.rsp.to_data = 1'b1;
          end
        end
        pasc_pkg::PASC_OP_TBL_RD: begin
          s_d.rsp.to_prog = 1'b1; // RULE21
          s_d.rsp.prog_upper = REQ_IN.high_word; // RULE20
          s_d.rsp.prog_cfg = s_q.tbl_page[pasc_pkg::PASC_TBL_CFG_BIT]; // RULE15
          s_d.rsp.addr = {s_q.tbl_page, ea}; // RULE14
        end
        pasc_pkg::PASC_OP_TBL_WR: begin
          s_d.rsp.is_write = 1'b1;
          s_d.rsp.prog_upper = REQ_IN.high_word; // RULE20
          s_d.rsp.prog_cfg = s_q.tbl_page[pasc_pkg::PASC_TBL_CFG_BIT]; // RULE15
          s_d.rsp.addr = {s_q.tbl_page, ea}; // RULE14
          // writes into configuration space never reach memory
          s_d.rsp.to_prog = ~s_q.tbl_page[pasc_pkg::PASC_TBL_CFG_BIT]; // RULE22
        end
        default: s_d.rsp.valid = 1'b0;
      endcase
    end
    s_d.stk_ptr = (REG_WR_IN && REG_ADDR_IN == pasc_pkg::PASC_OFF_STK_PTR) ?
      s_d.stk_ptr : sp_new;
    // sticky status: set wins over clear
    s_d.sticky = s_d.sticky | {(s_d.rsp.valid && !s_d.rsp.to_prog && !s_d.rsp.to_data &&
      (REQ_IN.op == pasc_pkg::PASC_OP_TBL_WR)), s_d.rsp.stk_err, s_d.rsp.addr_err};
  end
  // state register; stack limit deliberately left without reset value
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      s_q.rd_page <= pasc_pkg::PASC_RST_RD_PAGE;
      s_q.wr_page <= pasc_pkg::PASC_RST_WR_PAGE;
      s_q.tbl_page <= pasc_pkg::PASC_RST_TBL_PAGE;
      s_q.stk_ptr <= pasc_pkg::PASC_RST_STK_PTR;
      s_q.sticky <= 3'h0;
      s_q.rdata <= 16'h0000;
      s_q.rsp <= '0;
    end else if (CE_IN) begin
      s_q.rd_page <= s_d.rd_page;
      s_q.wr_page <= s_d.wr_page;
      s_q.tbl_page <= s_d.tbl_page;
      s_q.stk_ptr <= s_d.stk_ptr;
      s_q.sticky <= s_d.sticky;
      s_q.rdata <= s_d.rdata;
      s_q.rsp <= s_d.rsp;
      // stack limit has no reset branch, so it stays undefined until loaded
      s_q.stk_limit <= s_d.stk_limit; // RULE10
    end
  end
  // outputs straight from flops
  assign REG_RDATA_OUT = s_q.rdata;
  assign RSP_OUT = s_q.rsp;

  // checks
  property p_zero_page_trap;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_RD && REQ_IN.indirect &&
       REQ_IN.ea[15] && s_q.rd_page == 10'h000) |=> (RSP_OUT.addr_err && !RSP_OUT.to_data);
  endproperty
  a_zero_page_trap: assert property (p_zero_page_trap) else $error("page zero no trap"); // RULE2
  property p_low_direct;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_WR && !REQ_IN.ea[15])
      |=> (RSP_OUT.addr == {8'h00, $past(REQ_IN.ea)} && !RSP_OUT.addr_err);
  endproperty
  a_low_direct: assert property (p_low_direct) else $error("low address remapped"); // RULE1
  property p_psv_addr;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_RD && REQ_IN.indirect &&
       REQ_IN.ea[15] && s_q.rd_page[9]) |=> (RSP_OUT.to_prog && !RSP_OUT.prog_cfg &&
       RSP_OUT.addr[23] == 1'b0 && RSP_OUT.prog_upper == $past(s_q.rd_page[8]));
  endproperty
  a_psv_addr: assert property (p_psv_addr) else $error("program view wrong"); // RULE17
  property p_push_step;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && !REG_WR_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_PUSH &&
       s_q.stk_ptr <= s_q.stk_limit && s_q.stk_ptr >= 16'h0800)
      |=> (s_q.stk_ptr == $past(s_q.stk_ptr) + 16'h0002 && !RSP_OUT.stk_err);
  endproperty
  a_push_step: assert property (p_push_step) else $error("push step wrong"); // RULE7
  property p_over_limit;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_PUSH &&
       s_q.stk_ptr > s_q.stk_limit) |=> (RSP_OUT.stk_err && !RSP_OUT.to_data);
  endproperty
  a_over_limit: assert property (p_over_limit) else $error("overflow not trapped"); // RULE11
  property p_call_zero;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_PUSH &&
       REQ_IN.push_kind == pasc_pkg::PASC_PUSH_CALL) |=> RSP_OUT.data[15:8] == 8'h00;
  endproperty
  a_call_zero: assert property (p_call_zero) else $error("call upper byte set"); // RULE8
  property p_exc_flags;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_PUSH &&
       REQ_IN.push_kind == pasc_pkg::PASC_PUSH_EXC) |=> RSP_OUT.data[15:8] == $past(REQ_IN.flags);
  endproperty
  a_exc_flags: assert property (p_exc_flags) else $error("flags not pushed"); // RULE9
  property p_cfg_write;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REQ_IN.valid && REQ_IN.op == pasc_pkg::PASC_OP_TBL_WR && s_q.tbl_page[7])
      |=> (!RSP_OUT.to_prog && RSP_OUT.addr[23:16] == $past(s_q.tbl_page));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write passed"); // RULE22
  property p_trap_pulse;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && !REQ_IN.valid) |=> (!RSP_OUT.stk_err && !RSP_OUT.addr_err);
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap without access"); // RULE23
  property p_limit_lsb;
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
      (CE_IN && REG_RD_IN && REG_ADDR_IN == pasc_pkg::PASC_OFF_STK_LIMIT) |=> !REG_RDATA_OUT[0];
  endproperty
  a_limit_lsb: assert property (p_limit_lsb) else $error("limit bit 0 set"); // RULE10
  c_psv: cover property (@(posedge CLK_SYS_IN) RSP_OUT.to_prog && !RSP_OUT.is_write);
  c_stk_err: cover property (@(posedge CLK_SYS_IN) RSP_OUT.stk_err);
  c_addr_err: cover property (@(posedge CLK_SYS_IN) RSP_OUT.addr_err);
  c_tbl_cfg: cover property (@(posedge CLK_SYS_IN) RSP_OUT.prog_cfg && RSP_OUT.to_prog);
endmodule

/* hdl/pasc_pkg.sv */
// package: constants and carriers for the paged address and stack check block
// Notes on behaviour
// (RULE1) below 8000h page registers ignored, direct address
// (RULE2) page zero above 8000h raises address error
// (RULE3) pages 001h-1FFh select 32K extended windows
// (RULE4) write address is write page plus EA[14:0]
// (RULE5) read address is read page plus EA[14:0]
// (RULE6) working reg 15 is stack pointer, grows up
// (RULE7) pop predecrements, push postincrements stack pointer
// (RULE8) call push stores zero upper byte
// (RULE9) exception push stores flags in upper byte
// (RULE10) stack limit unreset, bit 0 reads zero
// (RULE11) push beyond equal limit raises stack error
// (RULE12) stack pointer below 0800h raises stack error
// (RULE13) software avoids stack read after limit write
// (RULE14) table address is table page over EA
// (RULE15) table page bit 7 selects configuration memory
// (RULE16) read page 10 bits, bit 9 selects program
// (RULE17) program view address is page[7:0] plus EA[14:0]
// (RULE18) read page bit 8 selects upper word
// (RULE19) program view reaches user memory only
// (RULE20) high table ops upper word, low lower word
// (RULE21) table reads allowed in configuration memory
// (RULE22) table writes to configuration memory refused
// (RULE23) traps are single-cycle pulses when address formed
package pasc_pkg;
  // register offsets (word indices on the plain port)
  localparam logic [3:0] PASC_OFF_RD_PAGE = 4'h0;
  localparam logic [3:0] PASC_OFF_WR_PAGE = 4'h1;
  localparam logic [3:0] PASC_OFF_TBL_PAGE = 4'h2;
  localparam logic [3:0] PASC_OFF_STK_LIMIT = 4'h3;
  localparam logic [3:0] PASC_OFF_STK_PTR = 4'h4;
  localparam logic [3:0] PASC_OFF_STATUS = 4'h5;
  // reset values
  localparam logic [9:0] PASC_RST_RD_PAGE = 10'h001;
  localparam logic [8:0] PASC_RST_WR_PAGE = 9'h001;
  localparam logic [7:0] PASC_RST_TBL_PAGE = 8'h00;
  localparam logic [15:0] PASC_RST_STK_PTR = 16'h0800;
  // address boundaries
  localparam logic [15:0] PASC_STK_FLOOR = 16'h0800;
  localparam int PASC_EA_WINDOW_BIT = 15;
  localparam int PASC_RD_PSV_BIT = 9;
  localparam int PASC_RD_UPPER_BIT = 8;
  localparam int PASC_TBL_CFG_BIT = 7;
  localparam logic [15:0] PASC_WORD_STEP = 16'h0002;
  // kind of access the core issues
  typedef enum logic [2:0] {
    PASC_OP_RD = 3'b000,
    PASC_OP_WR = 3'b001,
    PASC_OP_PUSH = 3'b010,
    PASC_OP_POP = 3'b011,
    PASC_OP_TBL_RD = 3'b100,
    PASC_OP_TBL_WR = 3'b101
  } pasc_op_t;
  // kind of push source for the upper program counter word
  typedef enum logic [1:0] {
    PASC_PUSH_DATA = 2'b00,
    PASC_PUSH_CALL = 2'b01,
    PASC_PUSH_EXC = 2'b10
  } pasc_push_t;
  // request from the core address path
  typedef struct packed {
    logic valid;
    pasc_op_t op;
    pasc_push_t push_kind;
    logic indirect;
    logic high_word;
    logic [15:0] ea;
    logic [15:0] data;
    logic [7:0] flags;
  } pasc_req_t;
  // answer towards memories and exception logic
  typedef struct packed {
    logic valid;
    logic to_data;
    logic to_prog;
    logic prog_upper;
    logic prog_cfg;
    logic is_write;
    logic [23:0] addr;
    logic [15:0] data;
    logic addr_err;
    logic stk_err;
  } pasc_rsp_t;
  // whole block state
  typedef struct packed {
    logic [9:0] rd_page;
    logic [8:0] wr_page;
    logic [7:0] tbl_page;
    logic [15:0] stk_limit;
    logic [15:0] stk_ptr;
    logic [2:0] sticky;
    logic [15:0] rdata;
    pasc_rsp_t rsp;
  } pasc_state_t;
endpackage

/* test/pasc_core_model.sv */
// request driver standing in for the processor core address path
`timescale 1ns/1ps
module pasc_core_model (
  // clock
  input wire logic clk_in,
  // request towards the block
  output pasc_pkg::pasc_req_t req_out
);
  // idle until the first call
  initial req_out = '0;
  // one request, held up to its taken edge, then valid drops
  // callers keep a stack read away from a fresh limit write
  task automatic send(input pasc_pkg::pasc_op_t op, input pasc_pkg::pasc_push_t pk,
    input logic hw, input logic [15:0] ea, input logic [15:0] d, input logic [7:0] f);
    @(posedge clk_in);
    req_out <= '{1'b1, op, pk, 1'b1, hw, ea, d, f};
    @(posedge clk_in);
    req_out.valid <= 1'b0;
  endtask
endmodule

/* test/pasc_core_tb.sv */
// self-checking bench for the address mapping and stack check block
`timescale 1ns/1ps
module pasc_core_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ra = 4'h0;
  logic [15:0] rw = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic ce = 1'b1;
  logic [15:0] rdata;
  pasc_pkg::pasc_req_t req;
  pasc_pkg::pasc_rsp_t rsp;
  pasc_pkg::pasc_rsp_t r;
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [15:0] v, ea, d;
  logic [9:0] p;
  logic [7:0] tp;
  logic w, hw, e;
  // 50 ns period
  always #25 clk = ~clk;
  pasc_core pasc_core_inst (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .REG_ADDR_IN(ra), .REG_WDATA_IN(rw), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s),
    .REG_RDATA_OUT(rdata), .REQ_IN(req), .RSP_OUT(rsp));
  pasc_core_model pasc_core_model_inst (.clk_in(clk), .req_out(req));
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wreg(input logic [3:0] a, input logic [15:0] dv);
    @(posedge clk);
    ra <= a;
    rw <= dv;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  // read strobe, data sampled in the following cycle only
  task automatic rreg(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    ra <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    q = rdata;
  endtask
  // request through the core model, answer captured mid-cycle
  task automatic acc(input pasc_pkg::pasc_op_t op, input pasc_pkg::pasc_push_t pk,
    input logic h, input logic [15:0] a, input logic [15:0] dv, input logic [7:0] f);
    pasc_core_model_inst.send(op, pk, h, a, dv, f);
    @(negedge clk);
    r = rsp;
  endtask
  // main sequence
  initial begin
    void'($urandom(66575));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rreg(4'h0, v); chk(v, 16'h0001);
    rreg(4'h1, v); chk(v, 16'h0001);
    rreg(4'h2, v); chk(v, 16'h0000);
    rreg(4'h4, v); chk(v, 16'h0800);
    rreg(4'hf, v); chk(v, 16'h0000);
    $display("test reset values done");
    // low region ignores pages; high region uses them, page 1FFh corner first
    for (int i = 0; i < 36; i++) begin
      p = (i == 0) ? 10'h1ff : 10'($urandom_range(511, 1));
      ea = (i == 0) ? 16'hfffe : 16'($urandom());
      if (i >= 18) ea[15] = 1'b0;
      if (i < 18) ea[15] = 1'b1;
      wreg(4'h0, {6'h00, p});
      wreg(4'h1, {6'h00, p});
      acc(pasc_pkg::PASC_OP_RD, pasc_pkg::PASC_PUSH_DATA, 1'b0, ea, 16'h0000, 8'h00);
      chk({r.to_data, r.addr}, {1'b1, ea[15] ? p[8:0] : 9'h000, ea[14:0]});
      d = 16'($urandom());
      acc(pasc_pkg::PASC_OP_WR, pasc_pkg::PASC_PUSH_DATA, 1'b0, ea, d, 8'h00);
      chk({r.is_write, r.addr}, {1'b1, ea[15] ? p[8:0] : 9'h000, ea[14:0]});
    end
    $display("test extended window done");
    wreg(4'h0, 16'h0000);
    wreg(4'h1, 16'h0000);
    acc(pasc_pkg::PASC_OP_RD, pasc_pkg::PASC_PUSH_DATA, 1'b0, 16'h8000, 16'h0, 8'h0);
    chk({r.addr_err, r.to_data, r.to_prog}, 3'b100);
    @(negedge clk); chk(rsp.addr_err, 1'b0);
    acc(pasc_pkg::PASC_OP_WR, pasc_pkg::PASC_PUSH_DATA, 1'b0, 16'hc000, 16'h0, 8'h0);
    chk({r.addr_err, r.to_data, r.to_prog}, 3'b100);
    // program view, lower then upper word
    for (int i = 0; i < 2; i++) begin
      wreg(4'h0, i[0] ? 16'h0302 : 16'h0202);
      acc(pasc_pkg::PASC_OP_RD, pasc_pkg::PASC_PUSH_DATA, 1'b0, 16'h800a, 16'h0, 8'h0);
      chk({r.to_prog, r.prog_upper, r.prog_cfg, r.addr}, {1'b1, i[0], 1'b0, 24'h01_000a});
    end
    $display("test page zero and program view done");
    // table ops: user and configuration pages, both words, read and write
    for (int i = 0; i < 8; i++) begin
      tp = i[2] ? 8'h81 : 8'h12;
      hw = i[1];
      w = i[0];
      wreg(4'h2, {8'h00, tp});
      acc(w ? pasc_pkg::PASC_OP_TBL_WR : pasc_pkg::PASC_OP_TBL_RD, pasc_pkg::PASC_PUSH_DATA,
        hw, 16'h4566, 16'h0, 8'h0);
      chk(r.to_prog, !(w && tp[7]));
      if (!(w && tp[7])) chk({r.prog_upper, r.prog_cfg, r.addr}, {hw, tp[7], tp, 16'h4566});
    end
    $display("test table access done");
    // limit two words above floor plus one; bit 0 dropped
    wreg(4'h3, 16'h0805);
    rreg(4'h3, v); chk(v, 16'h0804);
    for (int k = 0; k < 4; k++) begin
      d = 16'($urandom());
      acc(pasc_pkg::PASC_OP_PUSH, pasc_pkg::PASC_PUSH_CALL, 1'b0, 16'h0, d, 8'h5a);
      chk(r.stk_err, k == 3);
      if (k < 3) chk({r.addr[15:0], r.data}, {16'(16'h0800 + 2 * k), 8'h00, d[7:0]});
    end
    rreg(4'h4, v); chk(v, 16'h0806);
    for (int k = 0; k < 4; k++) begin
      acc(pasc_pkg::PASC_OP_POP, pasc_pkg::PASC_PUSH_DATA, 1'b0, 16'h0, 16'h0, 8'h0);
      e = (k == 3);
      chk(r.stk_err, e);
      if (!e) chk(r.addr[15:0], 16'(16'h0804 - 2 * k));
    end
    wreg(4'h3, 16'h0ffe);
    acc(pasc_pkg::PASC_OP_PUSH, pasc_pkg::PASC_PUSH_EXC, 1'b0, 16'h0, 16'h1234, 8'ha5);
    chk({r.stk_err, r.data}, {1'b0, 16'ha534});
    $display("test stack done");
    // frozen clock enable: a push is not taken and the pointer holds
    @(posedge clk);
    ce <= 1'b0;
    acc(pasc_pkg::PASC_OP_PUSH, pasc_pkg::PASC_PUSH_DATA, 1'b0, 16'h0, 16'h1111, 8'h00);
    chk(r.valid, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    rreg(4'h4, v); chk(v, 16'h0802);
    $display("test clock enable done");
    final_report();
  end
endmodule
